// ==== dv/lsbs_slave_model.sv ====
// full-width memory slave on the data bus, answering after a set wait
// assumes its inputs settle before the falling edge, where it acts
`timescale 1ns/100ps
`default_nettype none
module lsbs_slave_model (
    input  wire logic        clk,
    input  wire logic        read_strobe,
    input  wire logic        write_strobe,
    input  wire logic [7:0]  wait_cycles,
    input  wire logic [0:31] rd_word,
    output logic             ready,
    output logic [0:31]      data_read
);
    logic [7:0] cnt;
    initial begin
        ready = 1'b0;
        data_read = 32'h00000000;
        cnt = 8'h00;
    end
    // word-wide slave, so left-justified lanes are met trivially
    // read data inverts every cycle off ready so stale data never passes
    always @(negedge clk) begin
        if (!(read_strobe || write_strobe)) cnt = wait_cycles;
        if ((read_strobe || write_strobe) && !ready && cnt == 8'h00) begin
            ready = 1'b1;
            data_read = rd_word;
        end else begin
            ready = 1'b0;
            data_read = ~data_read;
            if (cnt != 8'h00) cnt = cnt - 8'h01;
        end
    end
endmodule : lsbs_slave_model
`default_nettype wire

// ==== dv/lsbs_steer_bench.sv ====
// bench for the lane steering block: all lane patterns, waits, refusals
// assumes lsbs_pkg, lsbs_steer and the slave model are compiled first
`timescale 1ns/100ps
`default_nettype none
module lsbs_steer_bench;
    localparam logic [0:31] WD = 32'h11223344;
    localparam logic [0:31] RD = 32'haabbccdd;
    localparam logic [0:29] HI = 30'h00000a5c;
    logic                 clk, arst_n, req_valid, req_ready, req_write, req_big_endian;
    logic                 req_error, load_valid, transfer_start_strobe, read_strobe;
    logic                 write_strobe, ready;
    lsbs_pkg::lsbs_size_t req_size, req_slave_width;
    logic [0:31]          req_addr, req_wdata, load_data, bus_addr, data_write, data_read;
    logic [0:3]           byte_enable;
    logic [7:0]           slv_wait;
    logic [0:3]           le_byte_enable;
    logic [0:31]          le_data_write, le_load_data;
    int                   fail_count, comparisons;

    lsbs_steer #(.MEM_MGMT_LEVEL_PARAM(2'h2), .REORDER_PARAM(1'h0)) dut (
        .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_size(req_size), .req_slave_width(req_slave_width),
        .req_big_endian(req_big_endian), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_error(req_error), .load_valid(load_valid), .load_data(load_data),
        .transfer_start_strobe(transfer_start_strobe), .bus_addr(bus_addr),
        .byte_enable(byte_enable), .data_write(data_write), .read_strobe(read_strobe),
        .write_strobe(write_strobe), .data_read(data_read), .ready(ready));
    lsbs_slave_model slave (.clk(clk), .read_strobe(read_strobe), .write_strobe(write_strobe),
        .wait_cycles(slv_wait), .rd_word(RD), .ready(ready), .data_read(data_read));
    // copy built without big-endian support; its sequencing ignores byte order,
    // so it can share the slave's answers and must stay little-endian
    lsbs_steer dut_le (
        .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(),
        .req_write(req_write), .req_size(req_size), .req_slave_width(req_slave_width),
        .req_big_endian(req_big_endian), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_error(), .load_valid(), .load_data(le_load_data),
        .transfer_start_strobe(), .bus_addr(), .byte_enable(le_byte_enable),
        .data_write(le_data_write), .read_strobe(), .write_strobe(),
        .data_read(data_read), .ready(ready));

    // 40 mhz core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [0:31] exp, input logic [0:31] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    // request held across exactly one rising edge; only issued while idle
    task automatic request(input logic wr, input lsbs_pkg::lsbs_size_t sz,
                           input lsbs_pkg::lsbs_size_t wid, input logic bem, input logic [1:0] ofs);
        @(negedge clk);
        chk_bit("idle ready", 1'b1, req_ready);
        req_valid = 1'b1;
        req_write = wr;
        req_size = sz;
        req_slave_width = wid;
        req_big_endian = bem;
        req_addr = {HI, ofs};
        @(negedge clk);
        req_valid = 1'b0;
    endtask : request

    // expected lanes come from size and offset; loads are zero-extended
    task automatic xfer(input logic wr, input lsbs_pkg::lsbs_size_t sz, input logic bem,
                        input logic [1:0] ofs, input logic [7:0] wt);
        int n;
        int lane;
        logic [0:31] mask;
        logic done;
        int lane_le;
        logic [0:31] mask_le;
        n = (sz == lsbs_pkg::LSBS_SZ_WORD) ? 4 : (sz == lsbs_pkg::LSBS_SZ_HALF) ? 2 : 1;
        lane = bem ? ofs : 4 - n - ofs;
        mask = ~(32'hffffffff >> (8 * n)) >> (8 * lane);
        lane_le = 4 - n - ofs;
        mask_le = ~(32'hffffffff >> (8 * n)) >> (8 * lane_le);
        slv_wait = wt;
        done = 1'b0;
        request(wr, sz, sz, bem, ofs);
        chk_bit("start strobe", 1'b1, transfer_start_strobe);
        chk("address", {HI, ofs}, bus_addr);
        chk("lanes", {28'h0, 4'hf << (4 - n) >> lane}, {28'h0, byte_enable});
        chk_bit("strobe kind", 1'b1, wr ? write_strobe : read_strobe);
        if (wr) chk("store data", WD << (32 - 8 * n) >> (8 * lane), data_write & mask);
        chk("forced little lanes", {28'h0, 4'hf << (4 - n) >> lane_le},
            {28'h0, le_byte_enable});
        if (wr) chk("forced little data", WD << (32 - 8 * n) >> (8 * lane_le),
                    le_data_write & mask_le);
        // bounded wait for the bus strobes to drop after ready
        for (int i = 0; i < 40 && done !== 1'b1; i++) begin
            @(negedge clk);
            done = !(read_strobe || write_strobe);
            if (done !== 1'b1) chk_bit("quiet bus", 1'b0, transfer_start_strobe || byte_enable != 4'h0);
        end
        if (done !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
        if (!wr) chk_bit("load valid", 1'b1, load_valid);
        if (!wr) chk("load data", (RD & mask) >> (8 * (4 - n - lane)), load_data);
        if (!wr) chk("forced little load", (RD & mask_le) >> (8 * (4 - n - lane_le)),
                     le_load_data);
    endtask : xfer

    task automatic test_bytes();
        for (int b = 0; b < 2; b++)
            for (int w = 0; w < 2; w++)
                for (int o = 0; o < 4; o++)
                    xfer(w[0], lsbs_pkg::LSBS_SZ_BYTE, b[0], o[1:0], o[7:0]);
        $display("byte lane test done");
    endtask : test_bytes

    task automatic test_halves();
        for (int b = 0; b < 2; b++)
            for (int w = 0; w < 2; w++)
                for (int o = 0; o < 4; o += 2)
                    xfer(w[0], lsbs_pkg::LSBS_SZ_HALF, b[0], o[1:0], 8'h01);
        $display("halfword lane test done");
    endtask : test_halves

    task automatic test_words();
        xfer(1'b1, lsbs_pkg::LSBS_SZ_WORD, 1'b0, 2'h0, 8'h05);
        xfer(1'b0, lsbs_pkg::LSBS_SZ_WORD, 1'b1, 2'h0, 8'h00);
        $display("word test done");
    endtask : test_words

    // misaligned or too wide for the slave: error pulse, bus untouched
    task automatic refuse(input lsbs_pkg::lsbs_size_t sz, input lsbs_pkg::lsbs_size_t wid,
                          input logic [1:0] ofs);
        request(1'b1, sz, wid, 1'b0, ofs);
        chk_bit("refused", 1'b1, req_error);
        chk_bit("no transfer", 1'b0, transfer_start_strobe || write_strobe);
        @(negedge clk);
    endtask : refuse

    task automatic test_refusals();
        refuse(lsbs_pkg::LSBS_SZ_HALF, lsbs_pkg::LSBS_SZ_HALF, 2'h1);
        refuse(lsbs_pkg::LSBS_SZ_WORD, lsbs_pkg::LSBS_SZ_WORD, 2'h2);
        refuse(lsbs_pkg::LSBS_SZ_HALF, lsbs_pkg::LSBS_SZ_BYTE, 2'h0);
        refuse(lsbs_pkg::LSBS_SZ_WORD, lsbs_pkg::LSBS_SZ_HALF, 2'h0);
        $display("refusal test done");
    endtask : test_refusals

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // reset for four cycles, then every scenario in turn
    initial begin
        fail_count = 0;
        comparisons = 0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_size = lsbs_pkg::LSBS_SZ_BYTE;
        req_slave_width = lsbs_pkg::LSBS_SZ_BYTE;
        req_big_endian = 1'b0;
        req_addr = 32'h00000000;
        req_wdata = WD;
        slv_wait = 8'h00;
        repeat (4) @(negedge clk);
        chk_bit("reset quiet", 1'b0, transfer_start_strobe || read_strobe || write_strobe);
        arst_n = 1'b1;
        test_bytes();
        test_halves();
        test_words();
        test_refusals();
        print_verdict();
    end
endmodule : lsbs_steer_bench
`default_nettype wire

// ==== src/lsbs_cfg.svh ====
// constants for the load/store byte lane steering block
// assumes msb-zero bit order on every bus and register vector
`ifndef LSBS_CFG_SVH
`define LSBS_CFG_SVH

// lane enable patterns at lane 0, shifted right by the lane index
`define LSBS_BE_NONE      4'h0
`define LSBS_BE_BYTE0     4'h8
`define LSBS_BE_HALF0     4'hc
`define LSBS_BE_WORD      4'hf

// memory management level above which big-endian is allowed
`define LSBS_MMU_BE_MIN   2'h1
`define LSBS_REORDER_ON   1'h1

// field positions inside msb-zero words
`define LSBS_OFS_HI       30
`define LSBS_OFS_LO       31
`define LSBS_LSB_BYTE     24
`define LSBS_LSB_HALF     16
`define LSBS_ZERO24       24'h000000
`define LSBS_ZERO16       16'h0000
`define LSBS_ZERO32       32'h00000000

`endif

// ==== src/lsbs_pkg.sv ====
// types for the load/store byte lane steering block
// assumes lsbs_cfg.svh supplies the numeric constants
package lsbs_pkg;

    // transfer size and attached slave width share one encoding
    typedef enum logic [1:0] {
        LSBS_SZ_BYTE = 2'h0,
        LSBS_SZ_HALF = 2'h1,
        LSBS_SZ_WORD = 2'h2
    } lsbs_size_t;

    // gray along idle -> start -> wait; wait -> idle flips both bits
    typedef enum logic [1:0] {
        LSBS_ST_IDLE  = 2'h0,
        LSBS_ST_START = 2'h1,
        LSBS_ST_WAIT  = 2'h3
    } lsbs_state_t;

endpackage : lsbs_pkg

// ==== src/lsbs_steer.sv ====
// data-side load/store lane steering: turns a core request into one bus
// transfer with lane enables and steered write data, and steers read data back.
// assumes the slave answers with ready in a later cycle and is on the core clock.
// Contract
// - byte/half/word to word, byte/half to half, byte-only to byte
// - refuse accesses wider than the addressed slave
// - big-endian only with mmu level or reorder
// - big-endian loads: lane equals offset, zero-extended
// - little-endian loads: mirrored lanes, zero-extended
// - big-endian store lane enables follow offset
// - little-endian store lane enables mirror offset
// - byte/half stores drive low register bytes
// - address, enables, data valid only with strobe
`timescale 1ns/100ps
`default_nettype none
`include "lsbs_cfg.svh"

module lsbs_steer #(
    parameter logic [1:0] MEM_MGMT_LEVEL_PARAM = 2'h0,
    parameter logic       REORDER_PARAM        = 1'h0
) (
    input  wire logic               clk,
    input  wire logic               arst_n,
    // core request side
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic               req_write,
    input  wire lsbs_pkg::lsbs_size_t req_size,
    input  wire lsbs_pkg::lsbs_size_t req_slave_width,
    input  wire logic               req_big_endian,
    input  wire logic [0:31]        req_addr,
    input  wire logic [0:31]        req_wdata,
    output logic                    req_error,
    output logic                    load_valid,
    output logic [0:31]             load_data,
    // data bus side
    output logic                    transfer_start_strobe,
    output logic [0:31]             bus_addr,
    output logic [0:3]              byte_enable,
    output logic [0:31]             data_write,
    output logic                    read_strobe,
    output logic                    write_strobe,
    input  wire logic [0:31]        data_read,
    input  wire logic               ready
);

    // big-endian steering exists only for these build options
    localparam logic BE_AVAIL = (MEM_MGMT_LEVEL_PARAM > `LSBS_MMU_BE_MIN) ||
                                (REORDER_PARAM == `LSBS_REORDER_ON);

    lsbs_pkg::lsbs_state_t state_q, state_d;
    lsbs_pkg::lsbs_size_t  size_q, size_d;
    logic                  write_q, write_d;
    logic [1:0]            lane_q, lane_d;
    logic [0:31]           addr_q, addr_d;
    logic [0:3]            be_q, be_d;
    logic [0:31]           wd_q, wd_d;
    logic                  err_q, err_d;
    logic                  lv_q, lv_d;
    logic [0:31]           ld_q, ld_d;

    logic [1:0]            off;
    logic                  big_eff;
    logic                  legal;
    logic [1:0]            lane;
    logic [4:0]            bit_ofs;
    logic [0:3]            be_new;
    logic [0:31]           wd_new;
    logic                  accept;
    logic [0:7]            rd_lane_byte;
    logic [0:15]           rd_lane_half;
    logic [0:7]            wd_lsb;

    // request decode; bits 30:31 are the least significant address bits
    assign off     = {req_addr[`LSBS_OFS_HI], req_addr[`LSBS_OFS_LO]};
    assign big_eff = req_big_endian && BE_AVAIL;
    assign req_ready = (state_q == lsbs_pkg::LSBS_ST_IDLE);
    assign accept  = req_valid && req_ready;

    // width and alignment check: no bus sizing, so wider or misaligned is refused
    always_comb begin
        unique case (req_size)
            lsbs_pkg::LSBS_SZ_BYTE: legal = 1'b1;
            lsbs_pkg::LSBS_SZ_HALF: legal = !off[0] &&
                                            (req_slave_width != lsbs_pkg::LSBS_SZ_BYTE);
            lsbs_pkg::LSBS_SZ_WORD: legal = (off == 2'h0) &&
                                            (req_slave_width == lsbs_pkg::LSBS_SZ_WORD);
            default:                legal = 1'b0;
        endcase
    end

    // lane selection: big-endian follows the offset, little-endian mirrors it
    always_comb begin
        lane   = 2'h0;
        be_new = `LSBS_BE_NONE;
        wd_new = `LSBS_ZERO32;
        unique case (req_size)
            lsbs_pkg::LSBS_SZ_BYTE: begin
                lane   = big_eff ? off : ~off;
                be_new = `LSBS_BE_BYTE0 >> lane;
            end
            lsbs_pkg::LSBS_SZ_HALF: begin
                lane   = big_eff ? off : {~off[1], 1'b0};
                be_new = `LSBS_BE_HALF0 >> lane;
            end
            default: begin
                lane   = 2'h0;
                be_new = `LSBS_BE_WORD;
            end
        endcase
        bit_ofs = {lane, 3'h0};
        // low register bytes land on the enabled lanes, in lane order
        unique case (req_size)
            lsbs_pkg::LSBS_SZ_BYTE: wd_new[bit_ofs +: 8]  = req_wdata[`LSBS_LSB_BYTE +: 8];
            lsbs_pkg::LSBS_SZ_HALF: wd_new[bit_ofs +: 16] = req_wdata[`LSBS_LSB_HALF +: 16];
            default:                wd_new = req_wdata;
        endcase
    end

    // read lanes picked with the lane saved at the start of the transfer
    assign rd_lane_byte = data_read[{lane_q, 3'h0} +: 8];
    assign rd_lane_half = data_read[{lane_q, 3'h0} +: 16];

    // low store byte kept as a signal so the store check can look one cycle back
    assign wd_lsb = req_wdata[`LSBS_LSB_BYTE +: 8];

    // transfer sequencing; bus qualifiers drop to zero after the start cycle
    always_comb begin
        state_d = state_q;
        size_d  = size_q;
        write_d = write_q;
        lane_d  = lane_q;
        addr_d  = `LSBS_ZERO32;
        be_d    = `LSBS_BE_NONE;
        wd_d    = `LSBS_ZERO32;
        err_d   = 1'b0;
        lv_d    = 1'b0;
        ld_d    = ld_q;
        unique case (state_q)
            lsbs_pkg::LSBS_ST_IDLE: begin
                if (accept && legal) begin
                    state_d = lsbs_pkg::LSBS_ST_START;
                    size_d  = req_size;
                    write_d = req_write;
                    lane_d  = lane;
                    addr_d  = req_addr;
                    be_d    = be_new;
                    wd_d    = req_write ? wd_new : `LSBS_ZERO32;
                end else if (accept) begin
                    err_d = 1'b1;
                end
            end
            lsbs_pkg::LSBS_ST_START, lsbs_pkg::LSBS_ST_WAIT: begin
                state_d = lsbs_pkg::LSBS_ST_WAIT;
                if (ready) begin
                    state_d = lsbs_pkg::LSBS_ST_IDLE;
                    lv_d    = !write_q;
                    // loads are zero-extended into the low register bits
                    if (!write_q) begin
                        unique case (size_q)
                            lsbs_pkg::LSBS_SZ_BYTE: ld_d = {`LSBS_ZERO24, rd_lane_byte};
                            lsbs_pkg::LSBS_SZ_HALF: ld_d = {`LSBS_ZERO16, rd_lane_half};
                            default:                ld_d = data_read;
                        endcase
                    end
                end
            end
            default: state_d = lsbs_pkg::LSBS_ST_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= lsbs_pkg::LSBS_ST_IDLE;
            size_q  <= lsbs_pkg::LSBS_SZ_BYTE;
            write_q <= 1'b0;
            lane_q  <= 2'h0;
            addr_q  <= `LSBS_ZERO32;
            be_q    <= `LSBS_BE_NONE;
            wd_q    <= `LSBS_ZERO32;
            err_q   <= 1'b0;
            lv_q    <= 1'b0;
            ld_q    <= `LSBS_ZERO32;
        end else begin
            state_q <= state_d;
            size_q  <= size_d;
            write_q <= write_d;
            lane_q  <= lane_d;
            addr_q  <= addr_d;
            be_q    <= be_d;
            wd_q    <= wd_d;
            err_q   <= err_d;
            lv_q    <= lv_d;
            ld_q    <= ld_d;
        end
    end

    // strobes decode from state; left-justified narrow slaves need no extra logic
    assign transfer_start_strobe = (state_q == lsbs_pkg::LSBS_ST_START);
    assign read_strobe  = (state_q != lsbs_pkg::LSBS_ST_IDLE) && !write_q;
    assign write_strobe = (state_q != lsbs_pkg::LSBS_ST_IDLE) && write_q;
    assign bus_addr     = addr_q;
    assign byte_enable  = be_q;
    assign data_write   = wd_q;
    assign req_error    = err_q;
    assign load_valid   = lv_q;
    assign load_data    = ld_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    strobe_one_cycle_a: assert property (transfer_start_strobe |=> !transfer_start_strobe)
        else $error("start strobe held more than one cycle");
    qual_zero_idle_a: assert property (!transfer_start_strobe |->
            (byte_enable == `LSBS_BE_NONE) && (data_write == `LSBS_ZERO32))
        else $error("lane enables or data valid without strobe");
    be_legal_a: assert property (transfer_start_strobe |-> byte_enable inside
            {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
        else $error("illegal lane enable pattern");
    wide_refused_a: assert property ((accept && (req_size > req_slave_width)) |=>
            req_error && !transfer_start_strobe)
        else $error("access wider than slave was issued");
    little_forced_a: assert property ((accept && legal && !BE_AVAIL &&
            (req_size == lsbs_pkg::LSBS_SZ_BYTE) && (off == 2'h3)) |=> (byte_enable == 4'h8))
        else $error("big-endian lanes used without option");
    byte_store_a: assert property ((accept && legal && req_write &&
            (req_size == lsbs_pkg::LSBS_SZ_BYTE)) |=>
            (data_write[{lane_q, 3'h0} +: 8] == $past(wd_lsb)))
        else $error("byte store data on wrong lane");
    word_store_a: assert property ((transfer_start_strobe && write_q &&
            (size_q == lsbs_pkg::LSBS_SZ_WORD)) |-> (byte_enable == `LSBS_BE_WORD))
        else $error("word store without all lanes");
    byte_load_a: assert property ((read_strobe && ready && (size_q == lsbs_pkg::LSBS_SZ_BYTE)) |=>
            load_valid && (load_data[0:23] == `LSBS_ZERO24) &&
            (load_data[24:31] == $past(rd_lane_byte)))
        else $error("byte load not steered to low byte");
    done_idle_a: assert property (((read_strobe || write_strobe) && ready) |=>
            req_ready && !read_strobe && !write_strobe)
        else $error("transfer did not end on ready");

endmodule : lsbs_steer
`default_nettype wire
